// File: pkg/pied_regs.svh
// Register offsets, field positions and reset values of the pin edge interrupt detector.
`ifndef PIED_REGS_SVH
`define PIED_REGS_SVH

// ********************************************************************
// Register port geometry
// ********************************************************************
`define PIED_ADDR_W 20
`define PIED_DATA_W 8

// ********************************************************************
// Register offsets
// ********************************************************************
`define PIED_OFS_EDGE_LOW 20'h0F024
`define PIED_OFS_EDGE_HIGH 20'h0F025
`define PIED_OFS_SAMPLE 20'h0F026
`define PIED_OFS_STATUS 20'h0F027
`define PIED_OFS_MASK 20'h0F028

// ********************************************************************
// Field positions, shared by every register of the block
// ********************************************************************
`define PIED_PA0_BIT 0
`define PIED_PA1_BIT 1
`define PIED_PA2_BIT 2
`define PIED_PB0_BIT 4
`define PIED_PB1_BIT 5
`define PIED_LIVE_BITS 8'h37

// ********************************************************************
// Reset values
// ********************************************************************
`define PIED_REG_RESET 8'h00
`define PIED_PINS_RESET 5'h00

`endif

// File: pkg/pied_pkg.sv
// Types shared by the pin edge interrupt detector modules.
package pied_pkg;

  // One bit per pin: PA0, PA1, PA2, PB0, PB1 from bit 0 upward.
  typedef logic [4:0] pied_pins_type;

  // Detection mode, high bit from the second edge register.
  typedef enum logic [1:0] {
    PIED_MODE_OFF,
    PIED_MODE_FALL,
    PIED_MODE_RISE,
    PIED_MODE_BOTH
  } pied_mode_type;

  // States of the per-pin sampling filter.
  typedef enum logic [1:0] {
    PIED_FILT_EMPTY,
    PIED_FILT_PRIMED,
    PIED_FILT_RUN
  } pied_filt_type;

endpackage : pied_pkg

// File: rtl/pied_sampler.sv
// Sampling filter of one pin, stepped by the low-speed 16 kHz tick.
`timescale 1ns/1ps

module pied_sampler import pied_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic sample_enable,
  input wire logic sample_strobe,
  input wire pied_mode_type mode,
  // Pin and result
  input wire logic pin_level,
  output logic hit
);

  pied_filt_type state;
  logic last_sample;
  logic settled;
  logic agree;
  logic moved;

  // A new level counts only once two samples in a row agree on it.
  assign agree = (pin_level == last_sample);
  assign moved = agree && (pin_level != settled);

  // Filter history; it restarts whenever sampling is switched off.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= PIED_FILT_EMPTY;
      last_sample <= 1'b0;
      settled <= 1'b0;
    end else if (!sample_enable) begin
      state <= PIED_FILT_EMPTY;
    end else if (sample_strobe) begin
      last_sample <= pin_level;
      unique case (state)
        PIED_FILT_EMPTY: begin
          state <= PIED_FILT_PRIMED;
        end
        PIED_FILT_PRIMED: begin
          // The first agreeing pair only fixes the reference level.
          if (agree) begin
            settled <= pin_level;
            state <= PIED_FILT_RUN;
          end
        end
        PIED_FILT_RUN: begin
          if (moved) begin
            settled <= pin_level;
          end
        end
        // The fourth code is unused; fall back to an empty history.
        default: begin
          state <= PIED_FILT_EMPTY;
        end
      endcase
    end
  end

  // R6: two high samples
  // R12: two samples of new level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hit <= 1'b0;
    end else if (sample_enable && sample_strobe && state == PIED_FILT_RUN && moved) begin
      unique case (mode)
        PIED_MODE_OFF: hit <= 1'b0;
        PIED_MODE_FALL: hit <= ~pin_level;
        PIED_MODE_RISE: hit <= pin_level;
        PIED_MODE_BOTH: hit <= 1'b1;
      endcase
    end else begin
      hit <= 1'b0;
    end
  end

endmodule : pied_sampler

// File: rtl/pied_top.sv
// Edge interrupt detector for three port A pins and two port B pins.
// ********************************************************************
// What this block does
// R1: Five pins, each its own maskable request.
// R2: Two bits per pin choose the edge.
// R3: Bits 0-2 port A, 4-5 port B.
// R4: Sampling bit selects direct or filtered path.
// R5: Filter stepped by the 16 kHz tick.
// R6: Rising needs two high tick samples.
// R7: Request follows second qualifying sample edge.
// R8: No sampling while in stop mode.
// R9: Port B edge raises its own request.
// R10: Port B requests maskable independently.
// R11: Direct path synchronises, compares, pulses once.
// R12: Falling and both need two samples.
// ********************************************************************
`timescale 1ns/1ps
`include "pied_regs.svh"

module pied_top import pied_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [`PIED_ADDR_W-1:0] reg_addr,
  input wire logic [`PIED_DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [`PIED_DATA_W-1:0] reg_rdata,
  // Pins, PA0 to PA2 then PB0 and PB1
  input wire logic [4:0] pin_in,
  // Low-speed time base and power state
  input wire logic low_speed_16k_tick,
  input wire logic stop_mode,
  // Interrupt requests
  output logic [4:0] pin_irq,
  output logic portb0_pin_irq,
  output logic portb1_pin_irq,
  output logic irq
);

  // ********************************************************************
  // Helper functions
  // ********************************************************************

  // Gathers the five live bits of a register into a pin vector.
  function automatic pied_pins_type to_pins(input logic [7:0] r);
    to_pins = {r[`PIED_PB1_BIT], r[`PIED_PB0_BIT], r[`PIED_PA2_BIT],
               r[`PIED_PA1_BIT], r[`PIED_PA0_BIT]};
  endfunction : to_pins

  // Spreads a pin vector back into register layout, gaps at zero.
  function automatic logic [7:0] to_reg(input pied_pins_type p);
    logic [7:0] r;
    r = 8'h00;
    r[`PIED_PA0_BIT] = p[0];
    r[`PIED_PA1_BIT] = p[1];
    r[`PIED_PA2_BIT] = p[2];
    r[`PIED_PB0_BIT] = p[3];
    r[`PIED_PB1_BIT] = p[4];
    to_reg = r;
  endfunction : to_reg

  // Tells whether a change from old to new matches the mode.
  function automatic logic edge_hit(input pied_mode_type m, input logic old_lvl,
                                    input logic new_lvl);
    logic h;
    h = 1'b0;
    unique case (m)
      PIED_MODE_OFF: h = 1'b0;
      PIED_MODE_FALL: h = old_lvl & ~new_lvl;
      PIED_MODE_RISE: h = ~old_lvl & new_lvl;
      PIED_MODE_BOTH: h = old_lvl ^ new_lvl;
    endcase
    edge_hit = h;
  endfunction : edge_hit

  // ********************************************************************
  // Declarations
  // ********************************************************************

  logic [7:0] edge_low;
  logic [7:0] edge_high;
  logic [7:0] sample_sel;
  logic [7:0] status;
  logic [7:0] mask;
  logic [7:0] next_rdata;
  logic [7:0] next_status;

  logic hit_edge_low;
  logic hit_edge_high;
  logic hit_sample;
  logic hit_status;
  logic hit_mask;

  pied_pins_type pin_meta;
  pied_pins_type pin_sync;
  pied_pins_type pin_prev;
  pied_pins_type direct_hit;
  pied_pins_type filter_hit;
  pied_pins_type event_pins;
  pied_pins_type sample_pins;
  pied_pins_type mask_pins;
  pied_pins_type next_irq;

  logic tick_meta;
  logic tick_sync;
  logic tick_prev;
  logic tick_fall;
  logic sample_strobe;

  pied_mode_type mode [5];

  // ********************************************************************
  // Register decode
  // ********************************************************************

  // Exact address compare; anything else is unmapped.
  assign hit_edge_low = (reg_addr == `PIED_OFS_EDGE_LOW);
  assign hit_edge_high = (reg_addr == `PIED_OFS_EDGE_HIGH);
  assign hit_sample = (reg_addr == `PIED_OFS_SAMPLE);
  assign hit_status = (reg_addr == `PIED_OFS_STATUS);
  assign hit_mask = (reg_addr == `PIED_OFS_MASK);

  // ********************************************************************
  // Control registers
  // ********************************************************************

  // R3: gap bits held at zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      edge_low <= `PIED_REG_RESET;
    end else if (reg_write && hit_edge_low) begin
      edge_low <= reg_wdata & `PIED_LIVE_BITS;
    end
  end

  // R3: gap bits held at zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      edge_high <= `PIED_REG_RESET;
    end else if (reg_write && hit_edge_high) begin
      edge_high <= reg_wdata & `PIED_LIVE_BITS;
    end
  end

  // R4: direct path after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sample_sel <= `PIED_REG_RESET;
    end else if (reg_write && hit_sample) begin
      sample_sel <= reg_wdata & `PIED_LIVE_BITS;
    end
  end

  // R10: mask per request
  // Masking sits after detection, so toggling it never loses edge state.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mask <= `PIED_REG_RESET;
    end else if (reg_write && hit_mask) begin
      mask <= reg_wdata & `PIED_LIVE_BITS;
    end
  end

  assign sample_pins = to_pins(sample_sel);
  assign mask_pins = to_pins(mask);

  // R2: high bit from second register
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      mode[i] = pied_mode_type'({edge_high[i < 3 ? i : i + 1], edge_low[i < 3 ? i : i + 1]});
    end
  end

  // ********************************************************************
  // Pin and tick synchronisers
  // ********************************************************************

  // Pins are asynchronous; the first stage feeds only the second.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= `PIED_PINS_RESET;
      pin_sync <= `PIED_PINS_RESET;
      pin_prev <= `PIED_PINS_RESET;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // R5: tick from time base
  // The tick comes from another clock, so it is synchronised too.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_meta <= 1'b0;
      tick_sync <= 1'b0;
      tick_prev <= 1'b0;
    end else begin
      tick_meta <= low_speed_16k_tick;
      tick_sync <= tick_meta;
      tick_prev <= tick_sync;
    end
  end

  // R6: sample on falling tick
  assign tick_fall = tick_prev & ~tick_sync;

  // R8: stop mode halts sampling
  assign sample_strobe = tick_fall & ~stop_mode;

  // ********************************************************************
  // Edge detection
  // ********************************************************************

  // R11: compare successive levels
  // One compare per cycle means an edge gives exactly one pulse.
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      direct_hit[i] = edge_hit(mode[i], pin_prev[i], pin_sync[i]);
    end
  end

  // R4: filtered path per pin
  for (genvar g = 0; g < 5; g++) begin : g_filter
    pied_sampler u_sampler (
      .clk(clk),
      .resetn(resetn),
      .sample_enable(sample_pins[g]),
      .sample_strobe(sample_strobe),
      .mode(mode[g]),
      .pin_level(pin_sync[g]),
      .hit(filter_hit[g])
    );
  end

  // R4: path chosen by sampling bit
  // R9: detected edge is the request
  assign event_pins = (sample_pins & filter_hit) | (~sample_pins & direct_hit);

  // ********************************************************************
  // Interrupt status and outputs
  // ********************************************************************

  // Write one to clear; a new event in the same cycle wins.
  always_comb begin
    next_status = status;
    if (reg_write && hit_status) begin
      next_status = status & ~reg_wdata;
    end
    next_status = (next_status | to_reg(event_pins)) & `PIED_LIVE_BITS;
  end

  // R1: sticky bit per pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status <= `PIED_REG_RESET;
    end else begin
      status <= next_status;
    end
  end

  // R10: mask gates pulses
  assign next_irq = event_pins & mask_pins;

  // R7: request one cycle after sample
  // The clock's falling edge is not used; the pulse lands on the next rising one.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_irq <= `PIED_PINS_RESET;
      portb0_pin_irq <= 1'b0;
      portb1_pin_irq <= 1'b0;
    end else begin
      pin_irq <= next_irq;
      portb0_pin_irq <= next_irq[3];
      portb1_pin_irq <= next_irq[4];
    end
  end

  // Level output, high while any unmasked status bit stands.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & mask);
    end
  end

  // ********************************************************************
  // Read port
  // ********************************************************************

  // Read mux; unmapped addresses answer zero.
  always_comb begin
    next_rdata = 8'h00;
    if (hit_edge_low) begin
      next_rdata = edge_low;
    end else if (hit_edge_high) begin
      next_rdata = edge_high;
    end else if (hit_sample) begin
      next_rdata = sample_sel;
    end else if (hit_status) begin
      next_rdata = status;
    end else if (hit_mask) begin
      next_rdata = mask;
    end
  end

  // Data stand only in the cycle after the read strobe.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : pied_top

// File: dv/pied_chk.sv
// Port checker of the pin edge interrupt detector.
`timescale 1ns/1ps

module pied_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Pins and tick
  input wire logic [4:0] pin_in,
  input wire logic low_speed_16k_tick,
  // Requests
  input wire logic [4:0] pin_irq,
  input wire logic portb0_pin_irq,
  input wire logic portb1_pin_irq,
  input wire logic irq
);
  logic [3:0] quiet;

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // Cycles since a pin moved or the tick fell; it saturates so a long idle never wraps.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      quiet <= 4'hF;
    end else if (pin_in != $past(pin_in) || $fell(low_speed_16k_tick)) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hF) begin
      quiet <= quiet + 4'h1;
    end
  end

  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("Read data not zero outside a read answer.");
  reserved_zero_a: assert property ($past(reg_read) |-> (reg_rdata & 8'hC8) == 8'h00)
    else $error("Reserved bits read as one.");
  portb0_copy_a: assert property (portb0_pin_irq == pin_irq[3])
    else $error("First port B request differs from its pin pulse.");
  portb1_copy_a: assert property (portb1_pin_irq == pin_irq[4])
    else $error("Second port B request differs from its pin pulse.");
  irq_follow_a: assert property (|pin_irq |-> irq)
    else $error("Pin pulse without the interrupt level.");
  irq_fall_a: assert property ($fell(irq) |-> $past(reg_write) || $past(reg_write, 2))
    else $error("Interrupt level dropped without a register write.");
  irq_rise_a: assert property ($rose(irq) |-> |pin_irq || $past(reg_write) || $past(reg_write, 2))
    else $error("Interrupt level rose without a cause.");
  pulse_cause_a: assert property (|pin_irq |-> quiet <= 4'h8)
    else $error("Pin pulse long after any pin or tick movement.");

  // Main scenarios reached.
  cover property (|pin_irq);
  cover property ($fell(irq));
  cover property ($past(reg_read) && reg_rdata != 8'h00);
endmodule : pied_chk

bind pied_top pied_chk pied_chk_inst (
  .clk(clk), .resetn(resetn), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .pin_in(pin_in), .low_speed_16k_tick(low_speed_16k_tick), .pin_irq(pin_irq),
  .portb0_pin_irq(portb0_pin_irq), .portb1_pin_irq(portb1_pin_irq), .irq(irq));

// File: dv/pied_tick_src.sv
// Low-speed time base model that makes the sampling tick.
`timescale 1ns/1ps

module pied_tick_src #(
  parameter int HALF = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Power state
  input wire logic stop_mode,
  // Tick
  output logic low_speed_16k_tick
);
  int cnt;

  // tick halts in stop
  // The period is far shorter than the real one so the run stays short.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      low_speed_16k_tick <= 1'b0;
    end else if (!stop_mode) begin
      if (cnt == HALF - 1) begin
        cnt <= 0;
        low_speed_16k_tick <= !low_speed_16k_tick;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : pied_tick_src

// File: dv/pied_top_bench.sv
// Self-checking bench of the pin edge interrupt detector.
`timescale 1ns/1ps
`include "pied_regs.svh"

module pied_top_bench;
  logic clk, resetn, reg_write, reg_read, stop_mode, tick;
  logic portb0_pin_irq, portb1_pin_irq, irq;
  logic [19:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [4:0] pin_in, pin_irq;
  int n_errors, total_checks;
  int cycles = 0;
  int hits = 0;

  pied_top pied_top_inst (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .low_speed_16k_tick(tick), .stop_mode(stop_mode), .pin_irq(pin_irq),
    .portb0_pin_irq(portb0_pin_irq), .portb1_pin_irq(portb1_pin_irq), .irq(irq));
  pied_tick_src pied_tick_src_inst (.clk(clk), .resetn(resetn), .stop_mode(stop_mode),
    .low_speed_16k_tick(tick));

  // Clock of 5 ns.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Count first-pin pulses and cut a hang short.
  always @(posedge clk) begin
    cycles++;
    if (pin_irq[0] === 1'b1) hits++;
    if (cycles == 5000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize;
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rd_chk(input logic [19:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask : rd_chk

  // Move one pin; a direct-path pulse shows three edges later for one cycle.
  task automatic pin_step(input int k, input logic lvl, input logic [4:0] exp);
    @(posedge clk);
    pin_in[k] <= lvl;
    repeat (3) @(posedge clk);
    #1 check({portb1_pin_irq, portb0_pin_irq, 1'b0, pin_irq}, {exp[4], exp[3], 1'b0, exp});
    @(posedge clk);
    #1 check({portb1_pin_irq, portb0_pin_irq, 1'b0, pin_irq}, 8'h00);
  endtask : pin_step

  function automatic logic [7:0] rbit(input int k);
    return (k < 3) ? (8'h01 << k) : (8'h01 << (k + 1));
  endfunction : rbit

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    resetn = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 20'h00000;
    reg_wdata = 8'h00;
    pin_in = 5'h00;
    stop_mode = 1'b0;
    n_errors = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    // Reset values, then one unmapped place above the map.
    for (int a = 0; a < 6; a++) rd_chk(`PIED_OFS_EDGE_LOW + 20'(a), 8'h00);
    wr(20'h0F029, 8'hFF);
    rd_chk(20'h0F029, 8'h00);
    for (int a = 0; a < 3; a++) begin
      wr(`PIED_OFS_EDGE_LOW + 20'(a), 8'hFF);
      rd_chk(`PIED_OFS_EDGE_LOW + 20'(a), 8'h37);
      wr(`PIED_OFS_EDGE_LOW + 20'(a), 8'h00);
    end
    wr(`PIED_OFS_MASK, 8'hFF);
    // Every mode on every pin, direct path.
    for (int k = 0; k < 5; k++) begin
      for (int m = 0; m < 4; m++) begin
        wr(`PIED_OFS_EDGE_LOW, m[0] ? rbit(k) : 8'h00);
        wr(`PIED_OFS_EDGE_HIGH, m[1] ? rbit(k) : 8'h00);
        pin_step(k, 1'b1, m[1] ? (5'h01 << k) : 5'h00);
        pin_step(k, 1'b0, m[0] ? (5'h01 << k) : 5'h00);
        rd_chk(`PIED_OFS_STATUS, (m != 0) ? rbit(k) : 8'h00);
        check({7'b0, irq}, 8'(m != 0));
        wr(`PIED_OFS_STATUS, rbit(k));
        repeat (2) @(posedge clk);
        #1 check({7'b0, irq}, 8'h00);
      end
    end
    // A masked port B request still sets status and shows on unmasking.
    wr(`PIED_OFS_MASK, 8'h17);
    pin_step(4, 1'b1, 5'h00);
    rd_chk(`PIED_OFS_STATUS, 8'h20);
    check({7'b0, irq}, 8'h00);
    wr(`PIED_OFS_MASK, 8'h37);
    repeat (2) @(posedge clk);
    #1 check({7'b0, irq}, 8'h01);
    wr(`PIED_OFS_STATUS, 8'h20);
    pin_step(4, 1'b0, 5'h10);
    // Filtered rising edge on the first pin.
    // The direct-path pass left four pulses on the first pin, so counts start at four.
    wr(`PIED_OFS_EDGE_HIGH, 8'h01);
    wr(`PIED_OFS_EDGE_LOW, 8'h00);
    wr(`PIED_OFS_SAMPLE, 8'h01);
    repeat (3) @(negedge tick);
    // A glitch inside the tick's high half is never sampled.
    @(posedge tick);
    @(posedge clk);
    pin_in[0] <= 1'b1;
    repeat (5) @(posedge clk);
    pin_in[0] <= 1'b0;
    repeat (3) @(negedge tick);
    check(8'(hits), 8'h04);
    @(negedge tick);
    @(posedge clk);
    pin_in[0] <= 1'b1;
    @(negedge tick);
    repeat (8) @(posedge clk);
    #1 check(8'(hits), 8'h04);
    @(negedge tick);
    repeat (8) @(posedge clk);
    #1 check(8'(hits), 8'h05);
    // Both edges while stopped: nothing until the tick runs again.
    wr(`PIED_OFS_EDGE_LOW, 8'h01);
    stop_mode <= 1'b1;
    @(posedge clk);
    pin_in[0] <= 1'b0;
    repeat (120) @(posedge clk);
    #1 check(8'(hits), 8'h05);
    @(posedge clk);
    stop_mode <= 1'b0;
    repeat (3) @(negedge tick);
    repeat (8) @(posedge clk);
    #1 check(8'(hits), 8'h06);
    summarize();
  end
endmodule : pied_top_bench
